// ### src/sne_defines.svh
// constants of the serial nand correction block: opcodes, offsets, fields
// assumes inclusion by bare name from the block's sources
`ifndef SNE_DEFINES_SVH
`define SNE_DEFINES_SVH
// link opcodes and feature addresses
`define SNE_OP_SETF 8'h1f
`define SNE_OP_GETF 8'h0f
`define SNE_OP_RST 8'hff
`define SNE_FA_CFG 8'hb0
`define SNE_FA_STS 8'hc0
`define SNE_CFG_ECC 4
`define SNE_CFG_RST 8'h10
`define SNE_STS_OUT 6:4
// page layout
`define SNE_SPARE_BASE 12'h800
`define SNE_PAR_BASE 12'h840
`define SNE_MAIN_SEL 10:9
`define SNE_SPARE_SEL 5:4
`define SNE_LANE_SEL 1:0
`define SNE_BBM_COL 12'h800
`define SNE_BBM_VAL 8'h00
`define SNE_MIN_GOOD_1G 16'h03ec
`define SNE_MIN_GOOD_2G 16'h07d8
// outcome codes and band limits
`define SNE_OC_NONE 3'h0
`define SNE_OC_LOW 3'h1
`define SNE_OC_UNC 3'h2
`define SNE_OC_MID 3'h3
`define SNE_OC_HIGH 3'h5
`define SNE_LIM_LOW 4'h3
`define SNE_LIM_MID 4'h6
`define SNE_LIM_MAX 4'h8
// register offsets and control bits
`define SNE_A_CTRL 8'h00
`define SNE_A_ERR 8'h04
`define SNE_A_STAT 8'h08
`define SNE_A_COL 8'h0c
`define SNE_A_DATA 8'h10
`define SNE_A_PAR0 8'h14
`define SNE_A_PAR3 8'h20
`define SNE_A_INFO 8'h24
`define SNE_C_RDGO 0
`define SNE_C_PCLR 1
`define SNE_C_NOPROT 2
`define SNE_RESP_OK 2'h0
`define SNE_RESP_ERR 2'h2
`endif

// ### src/sne_pkg.sv
// types of the serial nand correction block
// assumes no other package
package sne_pkg;
  typedef enum logic [2:0] {
    SNE_OP = 3'b000,
    SNE_ADDR = 3'b001,
    SNE_DATA = 3'b010,
    SNE_OUT = 3'b011,
    SNE_HOLD = 3'b100
  } sne_spi_st_t;
  typedef logic [2:0] sne_outcome_t;
endpackage : sne_pkg

// ### src/sne_ecc_core.sv
// serial nand correction engine: feature link, outcome code, parity, axi4-lite
// assumes aclk at 20 MHz, link pins asynchronous to it, sck much slower
`include "sne_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sne_ecc_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe
);
  logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_d_reg;
  logic sck_rise, sck_fall, cs_n_f, mosi_f;
  sne_pkg::sne_spi_st_t st_reg;
  logic [2:0] bit_reg;
  logic [6:0] sh_reg;
  logic [7:0] rx_byte, fa_reg, tx_reg, cfg_reg;
  logic byte_done, cfg_wr, rst_cmd, ecc_en;
  sne_pkg::sne_outcome_t outcome_reg;
  logic rd_go_reg, pclr_reg, noprot_reg;
  logic [15:0] err_reg;
  logic [11:0] col_reg;
  logic [31:0] par_reg [4];
  logic [3:0] max_err;
  logic wr_fire, rd_fire, wr_hit, prot_col;
  logic [1:0] sect;
  logic [31:0] rd_mux;
  logic rd_hit;

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      sync3_reg <= 3'h7;
      filt_reg <= 3'h7;
      filt_d_reg <= 3'h7;
    end else begin
      sync1_reg <= {spi_sck, spi_cs_n, spi_mosi};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_d_reg <= filt_reg;
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync3_reg[i];
        end
      end
    end
  end
  assign cs_n_f = filt_reg[1];
  assign mosi_f = filt_reg[0];
  assign sck_rise = filt_reg[2] & ~filt_d_reg[2] & ~cs_n_f;
  assign sck_fall = ~filt_reg[2] & filt_d_reg[2] & ~cs_n_f;
  assign rx_byte = {sh_reg, mosi_f};
  assign byte_done = sck_rise && (bit_reg == 3'h7);

  // link command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n_f) begin
      st_reg <= sne_pkg::SNE_OP;
      bit_reg <= 3'h0;
      sh_reg <= 7'h0;
      fa_reg <= 8'h0;
    end else if (sck_rise) begin
      bit_reg <= bit_reg + 3'h1;
      sh_reg <= rx_byte[6:0];
      if (byte_done) begin
        case (st_reg)
          sne_pkg::SNE_OP: begin
            if (rx_byte == `SNE_OP_SETF || rx_byte == `SNE_OP_GETF) begin
              st_reg <= sne_pkg::SNE_ADDR;
            end else begin
              st_reg <= sne_pkg::SNE_HOLD;
            end
            fa_reg <= rx_byte;
          end
          sne_pkg::SNE_ADDR: begin
            st_reg <= (fa_reg == `SNE_OP_SETF) ? sne_pkg::SNE_DATA : sne_pkg::SNE_OUT;
            fa_reg <= rx_byte;
          end
          sne_pkg::SNE_DATA: st_reg <= sne_pkg::SNE_HOLD;
          sne_pkg::SNE_OUT: st_reg <= sne_pkg::SNE_OUT;
          sne_pkg::SNE_HOLD: st_reg <= sne_pkg::SNE_HOLD;
          default: st_reg <= sne_pkg::SNE_HOLD;
        endcase
      end
    end
  end
  assign cfg_wr = byte_done && (st_reg == sne_pkg::SNE_DATA) && (fa_reg == `SNE_FA_CFG);
  assign rst_cmd = byte_done && (st_reg == sne_pkg::SNE_OP) && (rx_byte == `SNE_OP_RST);

  // feature read: value repeats each byte, driven on falling edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reg <= 8'h0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~cs_n_f && (st_reg == sne_pkg::SNE_OUT);
      if (byte_done && st_reg == sne_pkg::SNE_ADDR) begin
        tx_reg <= 8'h0;
        if (rx_byte == `SNE_FA_CFG) begin
          tx_reg <= cfg_reg;
        end else if (rx_byte == `SNE_FA_STS) begin
          tx_reg[`SNE_STS_OUT] <= outcome_reg;
        end
      end else if (sck_fall && st_reg == sne_pkg::SNE_OUT) begin
        spi_miso <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], tx_reg[7]};
      end
    end
  end

  // configuration survives the reset command, only power-up resets it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `SNE_CFG_RST;
    end else if (cfg_wr) begin
      cfg_reg <= rx_byte;
    end
  end
  assign ecc_en = cfg_reg[`SNE_CFG_ECC];

  // worst sector decides the outcome
  always_comb begin
    max_err = err_reg[3:0];
    for (int i = 1; i < 4; i++) begin
      if (err_reg[4*i +: 4] > max_err) begin
        max_err = err_reg[4*i +: 4];
      end
    end
  end

  function automatic sne_pkg::sne_outcome_t band(input logic [3:0] m);
    if (m == 4'h0) begin
      band = `SNE_OC_NONE;
    end else if (m <= `SNE_LIM_LOW) begin
      band = `SNE_OC_LOW;
    end else if (m <= `SNE_LIM_MID) begin
      band = `SNE_OC_MID;
    end else if (m <= `SNE_LIM_MAX) begin
      band = `SNE_OC_HIGH;
    end else begin
      band = `SNE_OC_UNC;
    end
  endfunction : band

  // a read completing in the same cycle as a reset command wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outcome_reg <= `SNE_OC_NONE;
    end else if (rd_go_reg && ecc_en && !noprot_reg) begin
      outcome_reg <= band(max_err);
    end else if (rst_cmd) begin
      outcome_reg <= `SNE_OC_NONE;
    end
  end

  // sector map; parity region is internal and takes no user bytes
  assign prot_col = col_reg < `SNE_PAR_BASE;
  assign sect = (col_reg < `SNE_SPARE_BASE) ? col_reg[`SNE_MAIN_SEL] : col_reg[`SNE_SPARE_SEL];

  // axi4-lite write side
  assign wr_fire = awvalid && awready && wvalid && wready;
  assign wr_hit = (awaddr == `SNE_A_CTRL) || (awaddr == `SNE_A_ERR) ||
                  (awaddr == `SNE_A_COL) || (awaddr == `SNE_A_DATA);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SNE_RESP_OK;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `SNE_RESP_OK : `SNE_RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control bits steer the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_go_reg <= 1'b0;
      pclr_reg <= 1'b0;
      noprot_reg <= 1'b0;
      err_reg <= 16'h0;
      col_reg <= 12'h0;
    end else begin
      rd_go_reg <= wr_fire && wstrb[0] && awaddr == `SNE_A_CTRL && wdata[`SNE_C_RDGO];
      pclr_reg <= wr_fire && wstrb[0] && awaddr == `SNE_A_CTRL && wdata[`SNE_C_PCLR];
      if (wr_fire && wstrb[0] && awaddr == `SNE_A_CTRL) begin
        noprot_reg <= wdata[`SNE_C_NOPROT];
      end
      if (wr_fire && awaddr == `SNE_A_ERR) begin
        if (wstrb[0]) begin
          err_reg[7:0] <= wdata[7:0];
        end
        if (wstrb[1]) begin
          err_reg[15:8] <= wdata[15:8];
        end
      end
      if (wr_fire && awaddr == `SNE_A_COL && wstrb[0] && wstrb[1]) begin
        col_reg <= wdata[11:0];
      end else if (wr_fire && awaddr == `SNE_A_DATA && wstrb[0]) begin
        col_reg <= col_reg + 12'h1;
      end
    end
  end

  // parity accumulates per sector while correction is on
  always_ff @(posedge aclk) begin
    if (!aresetn || pclr_reg) begin
      for (int i = 0; i < 4; i++) begin
        par_reg[i] <= 32'h0;
      end
    end else if (wr_fire && wstrb[0] && awaddr == `SNE_A_DATA && ecc_en &&
                 !noprot_reg && prot_col) begin
      par_reg[sect][8*col_reg[`SNE_LANE_SEL] +: 8] <=
        par_reg[sect][8*col_reg[`SNE_LANE_SEL] +: 8] ^ wdata[7:0];
    end
  end

  // read mux
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (araddr)
      `SNE_A_CTRL: rd_mux[`SNE_C_NOPROT] = noprot_reg;
      `SNE_A_ERR: rd_mux[15:0] = err_reg;
      `SNE_A_STAT: rd_mux = {16'h0, `SNE_BBM_VAL, cfg_reg[7:3], outcome_reg};
      `SNE_A_COL: rd_mux[11:0] = col_reg;
      `SNE_A_INFO: rd_mux = {`SNE_MIN_GOOD_2G, `SNE_MIN_GOOD_1G};
      default: begin
        if (araddr >= `SNE_A_PAR0 && araddr <= `SNE_A_PAR3 && araddr[1:0] == 2'h0) begin
          rd_mux = par_reg[2'(araddr[4:2] - 3'h5)];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // axi4-lite read side; unmapped reads answer with an error and touch no other state
  assign rd_fire = arvalid && arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `SNE_RESP_OK;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? `SNE_RESP_OK : `SNE_RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_go;
    rd_go_reg && ecc_en && !noprot_reg;
  endsequence
  sequence s_cfg_write;
    cfg_wr ##1 1'b1;
  endsequence

  a_cfg_ecc_bit: assert property (cfg_wr |=> ecc_en == $past(rx_byte[4]))
    else $error("enable flag not taken from feature write");
  a_powerup_on: assert property ($past(!aresetn) |-> ecc_en)
    else $error("correction off after power-up");
  a_reset_keeps_cfg: assert property (rst_cmd |=> $stable(cfg_reg))
    else $error("reset command altered configuration");
  a_reset_clears: assert property (rst_cmd && !rd_go_reg |=> outcome_reg == 3'h0)
    else $error("reset command left outcome set");
  a_band_low: assert property (s_read_go ##0 (max_err inside {[1:3]}) |=> outcome_reg == 3'h1)
    else $error("1-3 errors not coded 001");
  a_band_mid: assert property (s_read_go ##0 (max_err inside {[4:6]}) |=> outcome_reg == 3'h3)
    else $error("4-6 errors not coded 011");
  a_band_high: assert property (s_read_go ##0 (max_err inside {[7:8]}) |=> outcome_reg == 3'h5)
    else $error("7-8 errors not coded 101");
  a_uncorr_code: assert property (s_read_go ##0 (max_err > 4'h8) |=> outcome_reg == 3'h2)
    else $error("uncorrectable read not coded 010");
  a_clean_code: assert property (s_read_go ##0 (max_err == 4'h0) |=> outcome_reg == 3'h0)
    else $error("clean read not coded 000");
  a_bit0_corr: assert property (s_read_go ##0 (max_err inside {[1:8]}) |=> outcome_reg[0])
    else $error("bit 0 clear after correction");
  a_outcome_legal: assert property (!(outcome_reg inside {3'h4, 3'h6, 3'h7}))
    else $error("reserved outcome pattern");
  a_parity_off: assert property (!ecc_en && !pclr_reg |=> $stable(par_reg[0]))
    else $error("parity moved with correction off");
  a_unprot_hold: assert property (noprot_reg && rd_go_reg |=> $stable(outcome_reg))
    else $error("unprotected read changed outcome");
  a_cfg_seq: assert property (s_cfg_write |-> cfg_reg == $past(rx_byte))
    else $error("feature write value lost");
endmodule : sne_ecc_core
`default_nettype wire

// ### verif/sne_host_model.sv
// host side of the serial link: frames of opcode, feature address, data
// assumes sck idles low between frames, mode 0, msb first
`include "sne_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sne_host_model (
  // serial link
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  // read-back byte
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] d,
                       input int n);
    logic [23:0] sh;
    sh = {op, fa, d};
    // odd offset keeps link edges off the aclk edges
    #37 spi_cs_n = 1'b0;
    for (int i = 23; i >= 24 - n; i--) begin
      spi_mosi = sh[i];
      #200 spi_sck = 1'b1;
      // sample late in the high phase: miso lags the falling edge
      #150 if (i < 8) rx_byte[i] = (spi_miso_oe === 1'b1) ? spi_miso : 1'bx;
      #50 spi_sck = 1'b0;
    end
    #200 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    if (op == `SNE_OP_GETF) rx_stb = 1'b1;
    #50 rx_stb = 1'b0;
    #400;
  endtask : frame
endmodule : sne_host_model
`default_nettype wire

// ### verif/sne_ecc_core_test.sv
// self-checking bench of the correction engine over axi4-lite and the link
// assumes sne_ecc_core and sne_host_model are compiled first
`include "sne_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sne_ecc_core_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck, cs_n, mosi, miso, miso_oe, rx_stb;
  logic [7:0] awaddr, araddr, rx_byte, d1, d2, d3;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [7:0] exp_s[$];
  logic [15:0] e;
  logic [2:0] held;
  int n_mismatch, checked, cyc, k;
  sne_ecc_core u_sne_ecc_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(miso_oe));
  sne_host_model u_sne_host_model (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .rx_byte(rx_byte), .rx_stb(rx_stb));
  always #25 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [2:0] oc(input logic [15:0] v);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) if (v[4*i+:4] > m) m = v[4*i+:4];
    if (m == 4'h0) return `SNE_OC_NONE;
    if (m <= 4'h3) return `SNE_OC_LOW;
    if (m <= 4'h6) return `SNE_OC_MID;
    if (m <= 4'h8) return `SNE_OC_HIGH;
    return `SNE_OC_UNC;
  endfunction : oc
  function automatic logic [31:0] st(input logic [7:0] cfg, input logic [2:0] o);
    return {16'h0, `SNE_BBM_VAL, cfg[7:3], o};
  endfunction : st
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic spi(input logic [7:0] op, fa, d, input int n, input logic [7:0] ex);
    if (op == `SNE_OP_GETF) exp_s.push_back(ex);
    u_sne_host_model.frame(op, fa, d, n);
  endtask : spi
  // answers are judged in arrival order against the notes
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, exp_r.pop_front());
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  always @(posedge rx_stb) check({26'h0, rx_byte}, {26'h0, exp_s.pop_front()});
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cyc} = '0;
    {awaddr, araddr, wdata, n_mismatch, checked} = '0;
    wstrb = 4'hf;
    seed = 32'h01d8;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(`SNE_A_STAT, st(`SNE_CFG_RST, `SNE_OC_NONE), `SNE_RESP_OK);
    rd(`SNE_A_INFO, {`SNE_MIN_GOOD_2G, `SNE_MIN_GOOD_1G}, `SNE_RESP_OK);
    rd(8'h28, 32'h0, `SNE_RESP_ERR);
    wr(8'h28, 32'hffffffff, `SNE_RESP_ERR);
    spi(`SNE_OP_GETF, `SNE_FA_CFG, 8'h00, 24, `SNE_CFG_RST);
    // every count 0..9 lands on a random sector, others stay at or below it
    for (int c = 0; c < 10; c++) begin
      k = rnd() % 4;
      for (int s = 0; s < 4; s++) e[4*s+:4] = (s == k) ? 4'(c) : 4'(rnd() % (c + 1));
      wr(`SNE_A_ERR, {16'h0, e}, `SNE_RESP_OK);
      wr(`SNE_A_CTRL, 32'h1, `SNE_RESP_OK);
      rd(`SNE_A_STAT, st(`SNE_CFG_RST, oc(e)), `SNE_RESP_OK);
    end
    held = oc(e);
    spi(`SNE_OP_GETF, `SNE_FA_STS, 8'h00, 24, {1'b0, held, 4'h0});
    wr(`SNE_A_ERR, 32'h1, `SNE_RESP_OK);
    wr(`SNE_A_CTRL, 32'h4, `SNE_RESP_OK);
    wr(`SNE_A_CTRL, 32'h5, `SNE_RESP_OK);
    rd(`SNE_A_STAT, st(`SNE_CFG_RST, held), `SNE_RESP_OK);
    wr(`SNE_A_CTRL, 32'h0, `SNE_RESP_OK);
    d1 = 8'(rnd());
    d2 = 8'(rnd());
    d3 = 8'(rnd());
    wr(`SNE_A_COL, 32'h201, `SNE_RESP_OK);
    wr(`SNE_A_DATA, {24'h0, d1}, `SNE_RESP_OK);
    wr(`SNE_A_DATA, {24'h0, d2}, `SNE_RESP_OK);
    wr(`SNE_A_COL, 32'h832, `SNE_RESP_OK);
    wr(`SNE_A_DATA, {24'h0, d3}, `SNE_RESP_OK);
    wr(`SNE_A_COL, 32'h845, `SNE_RESP_OK);
    wr(`SNE_A_DATA, {24'h0, d3}, `SNE_RESP_OK);
    rd(8'h18, {8'h0, d2, d1, 8'h0}, `SNE_RESP_OK);
    rd(`SNE_A_PAR3, {8'h0, d3, 16'h0}, `SNE_RESP_OK);
    rd(`SNE_A_PAR0, 32'h0, `SNE_RESP_OK);
    wr(`SNE_A_CTRL, 32'h2, `SNE_RESP_OK);
    rd(8'h18, 32'h0, `SNE_RESP_OK);
    // correction off: parity and read outcome freeze; the reset command still clears the outcome
    spi(`SNE_OP_SETF, `SNE_FA_CFG, 8'h00, 24, 8'h00);
    wr(`SNE_A_COL, 32'h0, `SNE_RESP_OK);
    wr(`SNE_A_DATA, {24'h0, d1 | 8'h01}, `SNE_RESP_OK);
    rd(`SNE_A_PAR0, 32'h0, `SNE_RESP_OK);
    wr(`SNE_A_CTRL, 32'h1, `SNE_RESP_OK);
    rd(`SNE_A_STAT, st(8'h00, held), `SNE_RESP_OK);
    spi(`SNE_OP_RST, 8'h00, 8'h00, 8, 8'h00);
    rd(`SNE_A_STAT, st(8'h00, `SNE_OC_NONE), `SNE_RESP_OK);
    spi(`SNE_OP_GETF, `SNE_FA_CFG, 8'h00, 24, 8'h00);
    spi(`SNE_OP_SETF, `SNE_FA_CFG, `SNE_CFG_RST, 24, 8'h00);
    spi(`SNE_OP_SETF, `SNE_FA_STS, 8'h00, 24, 8'h00);
    spi(`SNE_OP_GETF, `SNE_FA_CFG, 8'h00, 24, `SNE_CFG_RST);
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule : sne_ecc_core_test
`default_nettype wire
